// >>> shared/icc_pkg.sv
// constants, opcodes and register map for the interrupt coprocessor
// Function
// - rising request edge sets its own latch
// - highest pending line wins, line 0 first
// - request edges latched every pclk, acted on once per instruction cycle end
// - vectors: line 0->4, 1->5, 2->6
// - service pushes the address of the instruction ending the cycle onto stack
// - service disables storage, drives vector jump
// - suspend low one cycle during source change
// - mask blocks service, latches keep state
// - inhibit input high blocks all service
// - clear-requests opcode clears all latches only
// - track level; preempt only by strictly higher
// - return pops, disables storage, drives jump
// - return also suspends controller one cycle
// - five special opcodes decoded from instruction bus
// - save-link pushes; program performs the jump
// - full flag high while four entries used
// - controller master clock is the timing reference
// - instruction bus driven only in forced cycles
// - save-link pushes own address plus two/one
// - mask auto-set at zero/service, cleared irq-return
// - push on full overwrites oldest entry
`default_nettype none
package icc_pkg;
  localparam int ADDR_W      = 13;
  localparam int INSTR_W     = 16;
  localparam int NUM_IRQ     = 3;
  localparam int STACK_DEPTH = 4;
  localparam int ENTRY_W     = 16;  // {is_irq, prev_lvl[1:0], addr[12:0]}
  localparam int ENT_IRQ_BIT = 15;
  localparam int ENT_LVL_LSB = 13;

  localparam logic [2:0] STACK_FULL_CNT = 3'h4;

  // special opcodes, instruction word bit 15 is the bus MSB
  localparam logic [INSTR_W-1:0] OP_SET_MASK  = 16'h0505;
  localparam logic [INSTR_W-1:0] OP_CLR_MASK  = 16'h0404;
  localparam logic [INSTR_W-1:0] OP_RETURN    = 16'h0606;
  localparam logic [INSTR_W-1:0] OP_SAVE_LINK = 16'h0303;
  localparam logic [INSTR_W-1:0] OP_CLR_REQ   = 16'h0202;

  // forced jump word: prefix in the top bits, target below
  localparam logic [2:0]        JMP_PREFIX = 3'h7;
  localparam logic [ADDR_W-1:0] VEC_BASE   = 13'h0004;
  localparam logic [ADDR_W-1:0] ADDR_ZERO  = 13'h0000;
  localparam logic [1:0]        LVL_NONE   = 2'h3;

  // apb register map
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_EN_BIT   = 0;
  localparam int ST_PEND_LSB   = 0;
  localparam int ST_MASK_BIT   = 3;
  localparam int ST_LVL_LSB    = 4;
  localparam int ST_DEPTH_LSB  = 6;
  localparam int ST_FULL_BIT   = 9;
  localparam int ST_OVF_BIT    = 10;
  localparam int ST_INHIB_BIT  = 11;
  localparam int ST_STATE_LSB  = 12;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HALT  = 2'b01,
    ST_FORCE = 2'b10
  } seq_state_t;
endpackage : icc_pkg
`default_nettype wire

// >>> src/return_stack.sv
// four-entry circular return stack that overwrites its oldest entry
`timescale 1ns/100ps
`default_nettype none
module return_stack
  import icc_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // control
  input  wire logic               clear,
  input  wire logic               push,
  input  wire logic               pop,
  input  wire logic [ENTRY_W-1:0] push_data,
  // state
  output logic      [ENTRY_W-1:0] top_data,
  output logic      [2:0]         depth,
  output logic                    full,
  output logic                    overflow
);
  logic [ENTRY_W-1:0] entry_reg [STACK_DEPTH];
  logic [1:0]         ptr_reg;
  logic [2:0]         count_reg;
  logic               ovf_reg;

  // one storage word per entry, written at the write pointer
  genvar i;
  generate
    for (i = 0; i < STACK_DEPTH; i++) begin : g_entry
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          entry_reg[i] <= '0;
        end else if (push && ptr_reg == 2'(i)) begin
          entry_reg[i] <= push_data;
        end
      end
    end
  endgenerate

  // pointer wraps, so a push on a full stack lands on the oldest word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg   <= 2'h0;
      count_reg <= 3'h0;
      ovf_reg   <= 1'b0;
    end else if (clear) begin
      ptr_reg   <= 2'h0;
      count_reg <= 3'h0;
      ovf_reg   <= 1'b0;
    end else if (push) begin
      ptr_reg <= ptr_reg + 2'h1;
      if (count_reg == STACK_FULL_CNT) begin
        ovf_reg <= 1'b1;  // oldest entry overwritten, depth stays at four
      end else begin
        count_reg <= count_reg + 3'h1;
      end
    end else if (pop && count_reg != 3'h0) begin
      ptr_reg   <= ptr_reg - 2'h1;
      count_reg <= count_reg - 3'h1;
    end
  end

  assign top_data = entry_reg[ptr_reg - 2'h1];
  assign depth    = count_reg;
  assign full     = (count_reg == STACK_FULL_CNT);
  assign overflow = ovf_reg;
endmodule : return_stack
`default_nettype wire

// >>> src/irq_coprocessor.sv
// interrupt and subroutine coprocessor beside a 16-bit microcontroller
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module irq_coprocessor
  import icc_pkg::*;
(
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic [11:0]        paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // controller buses
  input  wire logic               mclk_in,
  input  wire logic [ADDR_W-1:0]  prog_addr_bus,
  input  wire logic [INSTR_W-1:0] instr_bus_in,
  output logic      [INSTR_W-1:0] instr_bus_out,
  output logic                    instr_bus_oe,
  output logic                    prog_disable,
  output logic                    suspend_n,
  // interrupt pins and flags
  input  wire logic [NUM_IRQ-1:0] irq_req_in,
  input  wire logic               irq_inhibit_in,
  output logic                    stack_full_flag
);
  // synchronisers: stage 1 is read only by stage 2
  logic               mclk_s1, mclk_s2, mclk_s3;
  logic [NUM_IRQ-1:0] irq_s1, irq_s2, irq_s3;
  logic               inh_s1, inh_s2;
  logic [ADDR_W-1:0]  addr_s1, addr_s2;
  logic [INSTR_W-1:0] instr_s1, instr_s2;

  // core state
  seq_state_t         state_reg;
  logic [NUM_IRQ-1:0] irq_latch_reg;
  logic               mask_reg;
  logic               hold_reg;
  logic [1:0]         active_lvl_reg;
  logic [ADDR_W-1:0]  force_addr_reg;
  logic               ctrl_en_reg;

  // output flops
  logic [INSTR_W-1:0] instr_out_reg;
  logic               instr_oe_reg;
  logic               prog_disable_reg;
  logic               suspend_n_reg;
  logic               stack_full_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;

  // decode terms
  logic               cyc_end;
  logic               zero_hit;
  logic               decode_ok;
  logic               op_set_mask, op_clr_mask, op_return, op_save_link, op_clr_req;
  logic [NUM_IRQ-1:0] irq_rise;
  logic               any_pend;
  logic [1:0]         win_lvl;
  logic               svc_go;
  logic [NUM_IRQ-1:0] clr_vec;
  logic [ADDR_W-1:0]  link_addr;
  logic               stk_push;
  logic [ENTRY_W-1:0] stk_push_data;
  logic [ENTRY_W-1:0] stk_top;
  logic [2:0]         stk_depth;
  logic               stk_full;
  logic               stk_ovf;
  logic               top_is_irq;
  logic [1:0]         top_prev_lvl;

  // two-flop capture of every controller and interrupt pin; third stage only for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_s1  <= 1'b0;
      mclk_s2  <= 1'b0;
      mclk_s3  <= 1'b0;
      irq_s1   <= '0;
      irq_s2   <= '0;
      irq_s3   <= '0;
      inh_s1   <= 1'b0;
      inh_s2   <= 1'b0;
      addr_s1  <= '0;
      addr_s2  <= '0;
      instr_s1 <= '0;
      instr_s2 <= '0;
    end else begin
      mclk_s1  <= mclk_in;
      mclk_s2  <= mclk_s1;
      mclk_s3  <= mclk_s2;
      irq_s1   <= irq_req_in;
      irq_s2   <= irq_s1;
      irq_s3   <= irq_s2;
      inh_s1   <= irq_inhibit_in;
      inh_s2   <= inh_s1;
      addr_s1  <= prog_addr_bus;
      addr_s2  <= addr_s1;
      instr_s1 <= instr_bus_in;
      instr_s2 <= instr_s1;
    end
  end

  // the master clock rise closes one instruction cycle
  assign cyc_end  = mclk_s2 & ~mclk_s3;
  assign zero_hit = cyc_end && (addr_s2 == ADDR_ZERO);
  assign irq_rise = irq_s2 & ~irq_s3;

  // special opcodes only while memory feeds the bus and not at address zero
  assign decode_ok    = cyc_end && (state_reg == ST_IDLE) && !zero_hit;
  assign op_set_mask  = decode_ok && (instr_s2 == OP_SET_MASK);
  assign op_clr_mask  = decode_ok && (instr_s2 == OP_CLR_MASK);
  assign op_return    = decode_ok && (instr_s2 == OP_RETURN);
  assign op_save_link = decode_ok && (instr_s2 == OP_SAVE_LINK);
  assign op_clr_req   = decode_ok && (instr_s2 == OP_CLR_REQ);

  // fixed priority, line 0 first
  assign any_pend = |irq_latch_reg;
  assign win_lvl  = irq_latch_reg[0] ? 2'h0 : (irq_latch_reg[1] ? 2'h1 : 2'h2);

  // service gate: mask, inhibit pin, software enable, nesting level
  assign svc_go = decode_ok && !op_return && !op_save_link && !hold_reg
                  && !mask_reg && !inh_s2 && ctrl_en_reg && any_pend
                  && (win_lvl < active_lvl_reg);

  // latch clears: whole set on opcode, the winner on service
  always_comb begin
    clr_vec = '0;
    if (op_clr_req) begin
      clr_vec = '1;
    end else if (svc_go) begin
      clr_vec[win_lvl] = 1'b1;
    end
  end

  // request latches; a rising edge wins over an opcode or service clear in the same cycle, not over address zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_latch_reg <= '0;
    end else if (zero_hit) begin
      irq_latch_reg <= '0;  // address zero resets and latches nothing
    end else begin
      irq_latch_reg <= (irq_latch_reg & ~clr_vec) | irq_rise;
    end
  end

  // link address: odd slot skips the following jump, even slot does not
  assign link_addr = addr_s2[0] ? addr_s2 + 13'h0002 : addr_s2 + 13'h0001;

  // push return addresses for service and save-link
  assign stk_push      = svc_go || op_save_link;
  assign stk_push_data = svc_go ? {1'b1, active_lvl_reg, addr_s2} : {1'b0, LVL_NONE, link_addr};
  assign top_is_irq    = stk_top[ENT_IRQ_BIT];
  assign top_prev_lvl  = stk_top[ENT_LVL_LSB +: 2];

  return_stack u_stack (
    .clk       (pclk),
    .rst_n     (presetn),
    .clear     (zero_hit),
    .push      (stk_push),
    .pop       (op_return),
    .push_data (stk_push_data),
    .top_data  (stk_top),
    .depth     (stk_depth),
    .full      (stk_full),
    .overflow  (stk_ovf)
  );

  // mask: set at zero and on service, cleared by interrupt return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= 1'b1;
    end else if (zero_hit || svc_go) begin
      mask_reg <= 1'b1;
    end else if (op_return && top_is_irq) begin
      mask_reg <= 1'b0;  // subroutine return leaves the mask alone
    end else if (op_set_mask) begin
      mask_reg <= 1'b1;
    end else if (op_clr_mask) begin
      mask_reg <= 1'b0;
    end
  end

  // level in service; restored from the entry when its routine returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_lvl_reg <= LVL_NONE;
    end else if (zero_hit) begin
      active_lvl_reg <= LVL_NONE;
    end else if (svc_go) begin
      active_lvl_reg <= win_lvl;
    end else if (op_return && top_is_irq) begin
      active_lvl_reg <= top_prev_lvl;
    end
  end

  // no service on the instruction right after a save-link or return, keeps the stack sane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 1'b0;
    end else if (zero_hit) begin
      hold_reg <= 1'b0;
    end else if (op_save_link || op_return) begin
      hold_reg <= 1'b1;
    end else if (decode_ok) begin
      hold_reg <= 1'b0;
    end
  end

  // forced jump sequence: one suspended cycle, then one driven cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg        <= ST_IDLE;
      force_addr_reg   <= '0;
      suspend_n_reg    <= 1'b1;
      prog_disable_reg <= 1'b0;
      instr_oe_reg     <= 1'b0;
      instr_out_reg    <= '0;
    end else if (zero_hit) begin
      state_reg        <= ST_IDLE;
      suspend_n_reg    <= 1'b1;
      prog_disable_reg <= 1'b0;
      instr_oe_reg     <= 1'b0;
    end else if (cyc_end) begin
      case (state_reg)
        ST_IDLE: begin
          if (svc_go) begin
            state_reg      <= ST_HALT;
            force_addr_reg <= VEC_BASE + {11'h000, win_lvl};
            suspend_n_reg  <= 1'b0;
          end else if (op_return) begin
            state_reg      <= ST_HALT;
            force_addr_reg <= stk_top[ADDR_W-1:0];
            suspend_n_reg  <= 1'b0;
          end
        end
        ST_HALT: begin
          state_reg        <= ST_FORCE;
          suspend_n_reg    <= 1'b1;
          prog_disable_reg <= 1'b1;
          instr_oe_reg     <= 1'b1;
          instr_out_reg    <= {JMP_PREFIX, force_addr_reg};
        end
        ST_FORCE: begin
          state_reg        <= ST_IDLE;
          prog_disable_reg <= 1'b0;
          instr_oe_reg     <= 1'b0;
        end
        default: begin
          state_reg        <= ST_IDLE;
          suspend_n_reg    <= 1'b1;
          prog_disable_reg <= 1'b0;
          instr_oe_reg     <= 1'b0;
        end
      endcase
    end
  end

  // full flag re-timed so the pin leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_full_reg <= 1'b0;
    end else begin
      stack_full_reg <= stk_full;
    end
  end

  // apb control register: service enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_reg <= CTRL_RESET[CTRL_EN_BIT];
    end else if (psel && penable && pready_reg && pwrite && paddr == CTRL_OFS) begin
      ctrl_en_reg <= pwdata[CTRL_EN_BIT];
    end
  end

  // apb answer prepared in the setup cycle, so every access takes one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= psel && !penable;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
      if (psel && !penable) begin
        case (paddr)
          CTRL_OFS: begin
            prdata_reg[CTRL_EN_BIT] <= ctrl_en_reg;
          end
          STATUS_OFS: begin
            prdata_reg[ST_PEND_LSB +: NUM_IRQ] <= irq_latch_reg;
            prdata_reg[ST_MASK_BIT]            <= mask_reg;
            prdata_reg[ST_LVL_LSB +: 2]        <= active_lvl_reg;
            prdata_reg[ST_DEPTH_LSB +: 3]      <= stk_depth;
            prdata_reg[ST_FULL_BIT]            <= stk_full;
            prdata_reg[ST_OVF_BIT]             <= stk_ovf;
            prdata_reg[ST_INHIB_BIT]           <= inh_s2;
            prdata_reg[ST_STATE_LSB +: 2]      <= state_reg;
          end
          default: begin
            pslverr_reg <= 1'b1;  // unmapped word
          end
        endcase
      end
    end
  end

  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign instr_bus_out   = instr_out_reg;
  assign instr_bus_oe    = instr_oe_reg;
  assign prog_disable    = prog_disable_reg;
  assign suspend_n       = suspend_n_reg;
  assign stack_full_flag = stack_full_reg;

  // checks
  AST_LATCH_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_rise[1] && !zero_hit) |=> irq_latch_reg[1])
    else $error("request edge did not set its latch");

  AST_PRIORITY: assert property (@(posedge pclk) disable iff (!presetn)
    (svc_go && irq_latch_reg[0]) |-> (win_lvl == 2'h0) ##1 (!irq_latch_reg[0] || $past(irq_rise[0])))
    else $error("line 0 not served first");

  AST_SAMPLE_END: assert property (@(posedge pclk) disable iff (!presetn)
    svc_go |-> cyc_end && $past(!mclk_s2))
    else $error("service outside cycle end");

  AST_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)
    svc_go |=> force_addr_reg == VEC_BASE + {11'h000, $past(win_lvl)})
    else $error("wrong vector address");

  AST_HALT_START: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(suspend_n_reg) |-> $past(cyc_end) && state_reg == ST_HALT)
    else $error("suspend fell off a cycle end");

  AST_MASK_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    mask_reg |-> !svc_go)
    else $error("serviced while masked");

  AST_INHIBIT: assert property (@(posedge pclk) disable iff (!presetn)
    inh_s2 |-> !svc_go)
    else $error("serviced while inhibited");

  AST_CLEAR_REQ: assert property (@(posedge pclk) disable iff (!presetn)
    (op_clr_req && irq_rise == '0) |=> irq_latch_reg == '0)
    else $error("clear opcode left a latch set");

  AST_NESTING: assert property (@(posedge pclk) disable iff (!presetn)
    svc_go |-> win_lvl < active_lvl_reg ##1 active_lvl_reg == $past(win_lvl))
    else $error("nesting level broken");

  AST_FORCE_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(prog_disable_reg) |-> instr_oe_reg && suspend_n_reg && $past(!suspend_n_reg))
    else $error("forced jump not preceded by suspend");

  AST_BUS_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg != ST_FORCE) |-> !instr_oe_reg && !prog_disable_reg)
    else $error("bus driven outside forced cycle");

  AST_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    (stk_depth == STACK_FULL_CNT) |=> stack_full_flag)
    else $error("full flag missing");

  AST_MASK_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
    (svc_go || zero_hit) |=> mask_reg)
    else $error("mask not set automatically");
endmodule : irq_coprocessor
`default_nettype wire

// >>> dv/host_controller.sv
// controller and program memory model facing the coprocessor
`timescale 1ns/100ps
`default_nettype none
module host_controller
  import icc_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // coprocessor outputs
  input  wire logic [INSTR_W-1:0] forced_word,
  input  wire logic               forced_oe,
  input  wire logic               storage_off,
  input  wire logic               suspend_n,
  // controller buses
  output logic                    mclk,
  output logic      [ADDR_W-1:0]  addr,
  output logic      [INSTR_W-1:0] bus,
  // trace of executed words
  output logic                    exec_stb,
  output logic      [INSTR_W-1:0] exec_word,
  output logic      [ADDR_W-1:0]  exec_addr
);
  logic [INSTR_W-1:0] mem [0:127];
  logic [INSTR_W-1:0] last_reg;
  logic [ADDR_W-1:0]  nxt_reg;
  logic [2:0]         phase_reg;
  int                 pa [20] = '{1, 3, 4, 5, 6, 30, 33, 34, 35, 48, 50, 51, 60, 65, 66, 67, 80, 81, 96, 97};
  int                 pw [20] = '{16'h0404, 16'hE010, 16'hE020, 16'hE030, 16'hE040, 16'hE010, 16'h0303,
                                  16'hE060, 16'h0606, 16'h0404, 16'h0505, 16'h0404, 16'h0606, 16'h0303,
                                  16'hE050, 16'h0606, 16'h0202, 16'h0606, 16'h0303, 16'h0606};

  // program: vectors, main loop, three routines and nested subroutines
  initial begin
    foreach (mem[n]) mem[n] = 16'h0000;
    foreach (pa[n]) mem[pa[n]] = pw[n][15:0];
  end

  // released storage shows a pattern that changes every cycle, never a stale word
  assign bus = storage_off ? (forced_oe ? forced_word : ~last_reg) : mem[addr[6:0]];

  // eight pclk per instruction cycle; address moves while the clock is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 3'h0;
      mclk      <= 1'b0;
      addr      <= '0;
      nxt_reg   <= '0;
      last_reg  <= '0;
      exec_stb  <= 1'b0;
      exec_word <= '0;
      exec_addr <= '0;
    end else begin
      phase_reg <= phase_reg + 3'h1;
      exec_stb  <= 1'b0;
      last_reg  <= bus;
      if (phase_reg == 3'h3) begin
        mclk <= 1'b0;
        addr <= nxt_reg;
      end
      if (phase_reg == 3'h7) begin
        mclk <= 1'b1;
        if (suspend_n) begin  // a suspended cycle executes nothing
          exec_stb  <= 1'b1;
          exec_word <= bus;
          exec_addr <= addr;
          nxt_reg   <= (bus[15:13] == JMP_PREFIX) ? bus[ADDR_W-1:0] : addr + 13'h0001;
        end
      end
    end
  end
endmodule  // host_controller
`default_nettype wire

// >>> dv/prioritized_interrupt_coprocessor_bench.sv
// self-checking bench for the interrupt coprocessor with a controller model
`timescale 1ns/100ps
`default_nettype none
module prioritized_interrupt_coprocessor_bench
  import icc_pkg::*;
;
  localparam int CYC = 8;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, d;
  logic               mclk_in, instr_bus_oe, prog_disable, suspend_n, stack_full_flag, irq_inhibit_in;
  logic [ADDR_W-1:0]  prog_addr_bus, exec_addr;
  logic [INSTR_W-1:0] instr_bus_in, instr_bus_out, exec_word;
  logic [NUM_IRQ-1:0] irq_req_in;
  logic               exec_stb, oe_d;
  int                 miscompares, checks, jumps, sus_cnt, dis_cnt, lst_addr, lst_word, tgt, k, i;
  int                 lvl = 3;
  int                 aq[$], kq[$];
  bit   [2:0]         pend;
  bit                 msk = 1'b1;

  irq_coprocessor u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mclk_in(mclk_in), .prog_addr_bus(prog_addr_bus), .instr_bus_in(instr_bus_in),
    .instr_bus_out(instr_bus_out), .instr_bus_oe(instr_bus_oe), .prog_disable(prog_disable),
    .suspend_n(suspend_n), .irq_req_in(irq_req_in), .irq_inhibit_in(irq_inhibit_in),
    .stack_full_flag(stack_full_flag));
  host_controller u_host (.clk(pclk), .rst_n(presetn), .forced_word(instr_bus_out), .forced_oe(instr_bus_oe),
    .storage_off(prog_disable), .suspend_n(suspend_n), .mclk(mclk_in), .addr(prog_addr_bus),
    .bus(instr_bus_in), .exec_stb(exec_stb), .exec_word(exec_word), .exec_addr(exec_addr));

  always #5 pclk = ~pclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) miscompares++;
    @(posedge pclk);  // idle edge, so a following call never drives psel twice in one step
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk(d, exp);
    chk(e, eerr);
  endtask

  function automatic logic [31:0] st(input bit inh);
    return {20'h0, inh, 1'b0, aq.size() == 4, 3'(aq.size()), 2'(lvl), msk, pend};
  endfunction

  task automatic pulse(input int line);
    irq_req_in[line] <= 1'b1;
    pend[line] = 1'b1;
    repeat (4) @(posedge pclk);
    irq_req_in[line] <= 1'b0;
  endtask

  task automatic wait_jumps(input int n);
    int t;
    t = 0;
    while (jumps < n && t < 5000) begin
      @(posedge pclk);
      t++;
    end
    if (jumps < n) miscompares++;
  endtask

  // sequencer model: stack, level, mask and latches, checked at each forced jump
  always @(posedge pclk) begin
    oe_d <= instr_bus_oe;
    if (presetn) begin
      chk(instr_bus_oe, prog_disable);
      if (!suspend_n) sus_cnt++;
      else if (sus_cnt > 0) begin
        chk(sus_cnt, CYC);
        sus_cnt = 0;
      end
      if (prog_disable) dis_cnt++;
      else if (dis_cnt > 0) begin
        chk(dis_cnt, CYC);
        dis_cnt = 0;
      end
      if (instr_bus_oe && !oe_d) begin
        jumps++;
        if (lst_word == OP_RETURN) begin
          tgt = aq.pop_back();
          k = kq.pop_back();
          if (k >= 0) begin
            lvl = k;
            msk = 1'b0;
          end
        end else begin
          i = 0;
          while (i < 3 && !(pend[i] && i < lvl)) i++;
          tgt = 4 + i;
          aq.push_back(lst_addr);
          kq.push_back(lvl);
          lvl = i;
          msk = 1'b1;
          if (i < 3) pend[i] = 1'b0;
        end
        chk(instr_bus_out, {JMP_PREFIX, 13'(tgt)});
      end
      if (exec_stb) begin
        chk(stack_full_flag, aq.size() == 4);
        lst_addr = exec_addr;
        lst_word = exec_word;
        if (exec_word == OP_CLR_REQ) pend = 3'h0;
        if (exec_word == OP_CLR_MASK) msk = 1'b0;
        if (exec_word == OP_SET_MASK) msk = 1'b1;
        if (exec_word == OP_SAVE_LINK) begin
          aq.push_back(exec_addr[0] ? exec_addr + 13'h0002 : exec_addr + 13'h0001);
          kq.push_back(-1);
        end
      end
    end
  end

  // hang guard, far beyond the expected run length
  initial begin
    #400000;
    miscompares++;
    finish_test();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq_req_in = 3'h0;
    irq_inhibit_in = 1'b1;
    oe_d = 1'b0;
    void'($urandom(77358));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(CTRL_OFS, CTRL_RESET, 1'b0);
    rd_chk(STATUS_OFS, st(1'b1), 1'b0);
    rd_chk(12'h008, 32'h0, 1'b1);
    apb(1'b1, 12'h00C, $urandom());
    chk(e, 1'b1);
    repeat (40) @(posedge pclk);
    pulse(2);
    repeat ($urandom_range(1, 8)) @(posedge pclk);
    pulse(1);
    repeat (10) @(posedge pclk);
    rd_chk(STATUS_OFS, st(1'b1), 1'b0);
    irq_inhibit_in <= 1'b0;
    wait_jumps(1);
    pulse(0);
    wait_jumps(7);
    pulse(1);
    wait_jumps(9);
    repeat (100) @(posedge pclk);
    rd_chk(STATUS_OFS, st(1'b0), 1'b0);
    apb(1'b1, CTRL_OFS, 32'h0);
    pulse(0);
    repeat (60) @(posedge pclk);
    rd_chk(STATUS_OFS, st(1'b0), 1'b0);
    apb(1'b1, CTRL_OFS, 32'h1);
    wait_jumps(13);
    repeat (100) @(posedge pclk);
    rd_chk(STATUS_OFS, st(1'b0), 1'b0);
    finish_test();
  end
endmodule  // prioritized_interrupt_coprocessor_bench
`default_nettype wire
